// ### src/drcg_pkg.sv
// package for the dual-rank command gate and power-down block
// assumes a single clock MCLK that stands for the true/complement clock crossing
package drcg_pkg;
    localparam int RANK_COUNT       = 2;
    localparam int ADDR_WIDTH       = 17;
    localparam int MFC_WIDTH        = 3;
    localparam int MFC_LSB          = 14;
    localparam int BANK_COUNT       = 16;
    localparam int CMD_WIDTH        = 4;
    localparam logic [1:0] SR_IDLE  = 2'h0;
    // power state of one rank, one-hot
    typedef enum logic [3:0] {
        DRCG_ON  = 4'b0001,
        DRCG_PPD = 4'b0010,
        DRCG_APD = 4'b0100,
        DRCG_SR  = 4'b1000
    } drcg_state_type;
endpackage

// ### src/drcg_top.sv
// dual-rank command qualification and clock-enable power control
// assumes the controller drives selects, enables and command synchronous to MCLK
`timescale 1ns/1ns
module drcg_top
    import drcg_pkg::*;
#(
    parameter int RANKS = RANK_COUNT
) (
    input  wire logic                  MCLK,
    input  wire logic                  RESETN,
    input  wire logic                  RANK0_CLOCK_ENABLE,
    input  wire logic                  RANK1_CLOCK_ENABLE,
    input  wire logic                  RANK0_CHIP_SELECT_N,
    input  wire logic                  RANK1_CHIP_SELECT_N,
    input  wire logic                  RANK0_TERMINATION_ENABLE,
    input  wire logic                  RANK1_TERMINATION_ENABLE,
    input  wire logic                  ACTIVATE_N,
    input  wire logic [MFC_WIDTH-1:0]  CMD_IN,
    input  wire logic [ADDR_WIDTH-1:0] ADDR_IN,
    input  wire logic [RANKS-1:0]      SELF_REFRESH_REQ,
    input  wire logic [RANKS-1:0]      BANKS_OPEN,
    output logic      [RANKS-1:0]      CMD_VALID,
    output logic      [RANKS-1:0]      CMD_IS_ACTIVATE,
    output logic      [CMD_WIDTH-1:0]  CMD_CODE [RANKS],
    output logic      [ADDR_WIDTH-1:0] ROW_ADDR [RANKS],
    output logic      [RANKS-1:0]      TERM_ON,
    output logic      [RANKS-1:0]      CLOCKS_RUN,
    output logic      [RANKS-1:0]      CMD_BUF_ON,
    output logic      [RANKS-1:0]      CLK_BUF_ON,
    output logic      [RANKS-1:0]      TERM_BUF_ON,
    output logic      [RANKS-1:0]      IN_SELF_REFRESH,
    output logic      [RANKS-1:0]      IN_POWER_DOWN
);
    // ************************************************************
    // elaboration check
    // ************************************************************
    if (RANKS != RANK_COUNT) begin : g_bad_ranks
        $error("drcg_top serves exactly two ranks");
    end

    logic [RANKS-1:0] cke_in;
    logic [RANKS-1:0] cs_n_in;
    logic [RANKS-1:0] odt_in;
    assign cke_in  = {RANK1_CLOCK_ENABLE, RANK0_CLOCK_ENABLE};
    assign cs_n_in = {RANK1_CHIP_SELECT_N, RANK0_CHIP_SELECT_N};
    assign odt_in  = {RANK1_TERMINATION_ENABLE, RANK0_TERMINATION_ENABLE};

    // buffer enables per state
    function automatic logic [2:0] drcg_bufs(input drcg_state_type s);
        case (s)
            DRCG_ON:  drcg_bufs = 3'b111;
            DRCG_PPD: drcg_bufs = 3'b011;
            DRCG_APD: drcg_bufs = 3'b011;
            DRCG_SR:  drcg_bufs = 3'b000;
            default:  drcg_bufs = 3'b000;
        endcase
    endfunction

    // ************************************************************
    // per-rank logic
    // ************************************************************
    genvar r;
    for (r = 0; r < RANKS; r++) begin : g_rank
        drcg_state_type state_reg;
        drcg_state_type state_next;
        logic           cke_prev_reg;
        logic [2:0]     bufs;
        logic           powered;

        assign bufs    = drcg_bufs(state_reg);
        assign powered = (state_reg == DRCG_ON);

        always_comb begin
            state_next = state_reg;
            case (state_reg)
                DRCG_ON: begin
                    if (!cke_in[r] && cke_prev_reg) begin
                        if (BANKS_OPEN[r])
                            state_next = DRCG_APD;
                        else if (SELF_REFRESH_REQ[r] && !cs_n_in[r])
                            state_next = DRCG_SR;
                        else
                            state_next = DRCG_PPD;
                    end
                end
                DRCG_PPD, DRCG_APD: begin
                    if (cke_in[r])
                        state_next = DRCG_ON;
                end
                DRCG_SR: begin
                    if (cke_in[r])
                        state_next = DRCG_ON;
                end
                default: state_next = DRCG_ON;
            endcase
        end

        // state advances only on the rank's own inputs
        always_ff @(posedge MCLK) begin
            if (!RESETN) begin
                state_reg    <= DRCG_ON;
                cke_prev_reg <= 1'b0;
            end else begin
                state_reg    <= state_next;
                cke_prev_reg <= cke_in[r];
            end
        end

        // command capture on the clock crossing, masked by chip select
        always_ff @(posedge MCLK) begin
            if (!RESETN) begin
                CMD_VALID[r]       <= 1'b0;
                CMD_IS_ACTIVATE[r] <= 1'b0;
                CMD_CODE[r]        <= '0;
                ROW_ADDR[r]        <= '0;
            end else begin
                CMD_VALID[r] <= !cs_n_in[r] && powered && cke_in[r];
                if (!cs_n_in[r] && powered && cke_in[r]) begin
                    CMD_IS_ACTIVATE[r] <= !ACTIVATE_N;
                    if (!ACTIVATE_N) begin
                        ROW_ADDR[r] <= {CMD_IN, ADDR_IN[MFC_LSB-1:0]};
                        CMD_CODE[r] <= '0;
                    end else begin
                        ROW_ADDR[r] <= ADDR_IN;
                        CMD_CODE[r] <= {cs_n_in[r], CMD_IN};
                    end
                end
            end
        end

        always_ff @(posedge MCLK) begin
            if (!RESETN)
                TERM_ON[r] <= 1'b0;
            else
                TERM_ON[r] <= odt_in[r] && bufs[0];
        end

        assign CLOCKS_RUN[r]      = powered;
        assign CMD_BUF_ON[r]      = bufs[2];
        assign CLK_BUF_ON[r]      = bufs[1];
        assign TERM_BUF_ON[r]     = bufs[0];
        assign IN_SELF_REFRESH[r] = (state_reg == DRCG_SR);
        assign IN_POWER_DOWN[r]   = (state_reg == DRCG_PPD) || (state_reg == DRCG_APD);

        // ********************************************************
        // assertions
        // ********************************************************
        sequence s_cke_fall;
            cke_prev_reg && !cke_in[r] && powered;
        endsequence

        sequence s_taken;
            !cs_n_in[r] && powered && cke_in[r];
        endsequence

        a_masked_cmd: assert property (@(posedge MCLK) disable iff (!RESETN)
            cs_n_in[r] |=> !CMD_VALID[r])
            else $error("command taken with select high");
        a_open_row_apd: assert property (@(posedge MCLK) disable iff (!RESETN)
            s_cke_fall ##0 BANKS_OPEN[r] |=> state_reg == DRCG_APD)
            else $error("open row did not enter active power-down");
        a_idle_ppd: assert property (@(posedge MCLK) disable iff (!RESETN)
            s_cke_fall ##0 !BANKS_OPEN[r] |=> IN_POWER_DOWN[r] || IN_SELF_REFRESH[r])
            else $error("idle rank did not power down");
        a_pd_exit: assert property (@(posedge MCLK) disable iff (!RESETN)
            IN_POWER_DOWN[r] && cke_in[r] |=> powered)
            else $error("power-down exit missed");
        a_sr_exit: assert property (@(posedge MCLK) disable iff (!RESETN)
            IN_SELF_REFRESH[r] && cke_in[r] |=> powered)
            else $error("self-refresh exit missed");
        a_sr_buffers: assert property (@(posedge MCLK) disable iff (!RESETN)
            IN_SELF_REFRESH[r] |-> !CLK_BUF_ON[r] && !CMD_BUF_ON[r] && !TERM_BUF_ON[r])
            else $error("buffer on in self-refresh");
        a_pd_buffers: assert property (@(posedge MCLK) disable iff (!RESETN)
            IN_POWER_DOWN[r] |-> CLK_BUF_ON[r] && TERM_BUF_ON[r] && !CMD_BUF_ON[r])
            else $error("wrong buffers in power-down");
        a_act_row: assert property (@(posedge MCLK) disable iff (!RESETN)
            !cs_n_in[r] && powered && cke_in[r] && !ACTIVATE_N
            |=> CMD_IS_ACTIVATE[r] && ROW_ADDR[r][ADDR_WIDTH-1:MFC_LSB] == $past(CMD_IN))
            else $error("activate row bits wrong");
        a_clocks_stop: assert property (@(posedge MCLK) disable iff (!RESETN)
            s_cke_fall |=> !CLOCKS_RUN[r])
            else $error("clocks still run after enable low");
        a_cmd_taken: assert property (@(posedge MCLK) disable iff (!RESETN)
            s_taken |=> CMD_VALID[r])
            else $error("selected command not taken");
        a_cmd_code: assert property (@(posedge MCLK) disable iff (!RESETN)
            s_taken ##0 ACTIVATE_N |=> CMD_CODE[r] == {1'h0, $past(CMD_IN)})
            else $error("command code wrong");
        a_plain_row: assert property (@(posedge MCLK) disable iff (!RESETN)
            s_taken ##0 ACTIVATE_N |=> !CMD_IS_ACTIVATE[r] && ROW_ADDR[r] == $past(ADDR_IN))
            else $error("plain command address wrong");
        a_down_refuse: assert property (@(posedge MCLK) disable iff (!RESETN)
            !powered |=> !CMD_VALID[r])
            else $error("command taken while down");
        a_sr_entry: assert property (@(posedge MCLK) disable iff (!RESETN)
            s_cke_fall ##0 (!BANKS_OPEN[r] && SELF_REFRESH_REQ[r] && !cs_n_in[r])
            |=> IN_SELF_REFRESH[r])
            else $error("self-refresh entry missed");
        a_pd_term: assert property (@(posedge MCLK) disable iff (!RESETN)
            IN_POWER_DOWN[r] && odt_in[r] |=> TERM_ON[r])
            else $error("termination lost in power-down");
        a_sr_term: assert property (@(posedge MCLK) disable iff (!RESETN)
            IN_SELF_REFRESH[r] |=> !TERM_ON[r])
            else $error("termination on in self-refresh");
        a_run_buffers: assert property (@(posedge MCLK) disable iff (!RESETN)
            powered |-> CLK_BUF_ON[r] && CMD_BUF_ON[r] && TERM_BUF_ON[r])
            else $error("buffer off while running");
    end
endmodule // drcg_top

// ### bench/drcg_ctl_model.sv
// controller model: drives selects, clock enables and command bus
// assumes the block samples on rising clk; the model drives on falling clk
`timescale 1ns/1ns
module drcg_ctl_model
    import drcg_pkg::*;
(
    input  wire logic                  clk,
    output logic      [1:0]            cke,
    output logic      [1:0]            cs_n,
    output logic      [1:0]            odt,
    output logic      [1:0]            sr_req,
    output logic                       act_n,
    output logic      [MFC_WIDTH-1:0]  cmd,
    output logic      [ADDR_WIDTH-1:0] addr
);
    // ****
    // drive tasks
    // ****
    initial begin
        {cke, cs_n, odt, sr_req} = 8'hFC;
        {act_n, cmd, addr} = 21'h10_0000;
    end
    // one command, then deselect and invert the idle bus
    task automatic send(input int r, input logic a, input logic [2:0] c, input logic [16:0] d);
        @(negedge clk);
        cs_n[r] = 1'h0;
        {act_n, cmd, addr} = {a, c, d};
        @(negedge clk);
        cs_n = 2'h3;
        {cmd, addr} = ~{cmd, addr};
    endtask
    // enable change only between accesses, aligned to the edge
    task automatic set_cke(input int r, input logic v, input logic sr);
        @(negedge clk);
        cke[r] = v;
        sr_req[r] = sr;
        cs_n[r] = ~sr;
    endtask
    // termination request level for one rank
    task automatic set_odt(input int r, input logic v);
        @(negedge clk);
        odt[r] = v;
    endtask
endmodule // drcg_ctl_model

// ### bench/drcg_top_tb_top.sv
// testbench for the dual-rank command gate
// assumes the controller model drives the command-side inputs except banks_open, which the bench drives itself
`timescale 1ns/1ns
module drcg_top_tb_top;
    import drcg_pkg::*;
    // ****
    // signals and helpers
    // ****
    logic                  mclk = 1'h0;
    logic                  resetn = 1'h0;
    logic [1:0]            cke, cs_n, odt, sr_req, banks_open;
    logic                  act_n;
    logic [MFC_WIDTH-1:0]  cmd;
    logic [ADDR_WIDTH-1:0] addr;
    logic [1:0]            valid, is_act, term_on, clk_run, cmd_buf;
    logic [1:0]            clk_buf, term_buf, in_sr, in_pd;
    logic [CMD_WIDTH-1:0]  code [2];
    logic [ADDR_WIDTH-1:0] row [2];
    int                    fail_count = 0;
    int                    compares = 0;
    always #25 mclk = ~mclk;
    drcg_ctl_model u_ctl (.clk(mclk), .cke(cke), .cs_n(cs_n), .odt(odt),
        .sr_req(sr_req), .act_n(act_n), .cmd(cmd), .addr(addr));
    drcg_top u_dut (.MCLK(mclk), .RESETN(resetn),
        .RANK0_CLOCK_ENABLE(cke[0]), .RANK1_CLOCK_ENABLE(cke[1]),
        .RANK0_CHIP_SELECT_N(cs_n[0]), .RANK1_CHIP_SELECT_N(cs_n[1]),
        .RANK0_TERMINATION_ENABLE(odt[0]), .RANK1_TERMINATION_ENABLE(odt[1]),
        .ACTIVATE_N(act_n), .CMD_IN(cmd), .ADDR_IN(addr),
        .SELF_REFRESH_REQ(sr_req), .BANKS_OPEN(banks_open),
        .CMD_VALID(valid), .CMD_IS_ACTIVATE(is_act), .CMD_CODE(code),
        .ROW_ADDR(row), .TERM_ON(term_on), .CLOCKS_RUN(clk_run),
        .CMD_BUF_ON(cmd_buf), .CLK_BUF_ON(clk_buf), .TERM_BUF_ON(term_buf),
        .IN_SELF_REFRESH(in_sr), .IN_POWER_DOWN(in_pd));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // power view of one rank: run, cmd buf, clk buf, term buf, sr, pd
    function automatic logic [5:0] pw(input int r);
        return {clk_run[r], cmd_buf[r], clk_buf[r], term_buf[r], in_sr[r], in_pd[r]};
    endfunction
    task automatic summarize;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_cmd;
        u_ctl.send(0, 1'h0, 3'h5, 17'h0_2ABC);
        check(valid, 2'h1, "rank0 activate taken");
        check(is_act[0], 1'h1, "activate flag");
        check(row[0], 17'h1_6ABC, "upper row bits from command inputs");
        check(code[0], 4'h0, "no command code on activate");
        u_ctl.send(1, 1'h1, 3'h3, 17'h1_0001);
        check(valid, 2'h2, "rank1 only");
        check({is_act[1], code[1]}, 5'h03, "rank1 command code");
        check(row[1], 17'h1_0001, "plain address");
        @(posedge mclk);
        #1 check(valid, 2'h0, "valid lasts one cycle");
    endtask
    task automatic t_pd(input int r, input logic op, input logic sr, input logic [5:0] st);
        @(negedge mclk) banks_open[r] = op;
        u_ctl.set_odt(r, 1'h1);
        u_ctl.set_cke(r, 1'h0, sr);
        repeat (2) @(posedge mclk);
        #1 check(pw(r), st, "power state entry");
        check(pw(1 - r), 6'h3C, "other rank untouched");
        check(term_on[r], !sr, "termination kept only in power-down");
        u_ctl.send(r, 1'h1, 3'h1, 17'h0_0000);
        check(valid, 2'h0, "command refused while down");
        u_ctl.set_cke(r, 1'h1, 1'h0);
        repeat (2) @(posedge mclk);
        #1 check(pw(r), 6'h3C, "exit to running");
        check(term_on[r], 1'h1, "termination on while running");
        u_ctl.set_odt(r, 1'h0);
        @(posedge mclk);
        #1 check(term_on[r], 1'h0, "termination follows request");
    endtask
    // reset in mid-run from power-down; no false entry while enable is low
    task automatic t_reset;
        u_ctl.set_cke(0, 1'h0, 1'h0);
        @(negedge mclk) check(pw(0), 6'h0D, "down before mid-run reset");
        resetn = 1'h0;
        repeat (2) @(negedge mclk);
        check(pw(0), 6'h3C, "reset returns rank to running");
        check(valid, 2'h0, "no command during reset");
        resetn = 1'h1;
        u_ctl.set_cke(0, 1'h1, 1'h0);
        check(pw(0), 6'h3C, "no false entry after reset");
    endtask
    // ****
    // main sequence and watchdog
    // ****
    initial begin
        banks_open = 2'h0;
        repeat (20) @(posedge mclk);
        @(negedge mclk) resetn = 1'h1;
        check(pw(0), 6'h3C, "running after reset");
        t_cmd();
        t_pd(0, 1'h0, 1'h0, 6'h0D);
        t_pd(1, 1'h1, 1'h0, 6'h0D);
        t_pd(0, 1'h0, 1'h1, 6'h02);
        t_reset();
        summarize();
    end
    initial begin
        #20000;
        fail_count++;
        summarize();
    end
endmodule // drcg_top_tb_top
